/* gpt32_pkg.sv */
package gpt32_pkg;

    // Configuration codes for timer_config_reg
    localparam int CFG_W = 3;
    localparam logic [CFG_W-1:0] CFG_TIMER32 = 3'h0;
    localparam logic [CFG_W-1:0] CFG_RTC = 3'h1;
    localparam logic [CFG_W-1:0] CFG_SPLIT16 = 3'h4;

    // Codes of half_a_mode_field and its half-B twin
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_ONESHOT = 2'h1;
    localparam logic [MODE_W-1:0] MODE_PERIODIC = 2'h2;

    // Bit positions in timer_control_reg
    localparam int CTL_W = 6;
    localparam int CTL_EN_A = 0;
    localparam int CTL_EN_B = 1;
    localparam int CTL_OTE_A = 2;
    localparam int CTL_STALL_A = 3;
    localparam int CTL_STALL_B = 4;
    localparam int CTL_RTC_OVR = 5;

    // Bit positions in raw_irq_status, irq_mask_reg, irq_clear_reg
    localparam int IRQ_W = 3;
    localparam int IRQ_TO_A = 0;
    localparam int IRQ_TO_B = 1;
    localparam int IRQ_RTC = 2;

    // Widths and reset values
    localparam int HALF_W = 16;
    localparam int FULL_W = 32;
    localparam int PRE_W = 8;
    localparam logic [HALF_W-1:0] CNT16_RST = 16'hffff;
    localparam logic [HALF_W-1:0] LOAD16_RST = 16'hffff;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
    localparam logic [HALF_W-1:0] HALF_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRESCALE_RST = 8'h00;
    localparam logic [FULL_W-1:0] FULL_ZERO = 32'h0000_0000;
    localparam logic [FULL_W-1:0] FULL_ONE = 32'h0000_0001;
    localparam logic [FULL_W-1:0] RTC_FIRST_LOAD = 32'h0000_0001;
    localparam logic [FULL_W-1:0] MATCH_RST = 32'h0000_0000;

    // Real-time clock input rate and count rate, in Hz
    localparam int unsigned RTC_CLK_HZ = 32768;
    localparam int unsigned RTC_TICK_HZ = 1;
    localparam int unsigned RTC_DIV_EDGES = RTC_CLK_HZ / RTC_TICK_HZ;
    localparam int RTC_DIV_W = 16;

endpackage

/* gpt32_rtc_divider.sv */
`timescale 1ns/100ps
// Turns the slow pin clock into a one-cycle tick every div_edges rising edges
module gpt32_rtc_divider #(
    parameter int unsigned div_edges = gpt32_pkg::RTC_DIV_EDGES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic [gpt32_pkg::RTC_DIV_W-1:0] edges;
        logic tick;
    } gpt32_div_state_type;

    localparam logic [gpt32_pkg::RTC_DIV_W-1:0] EDGE_LAST =
        gpt32_pkg::RTC_DIV_W'(div_edges - 1);

    gpt32_div_state_type s_reg;
    gpt32_div_state_type s_next;
    logic rise;

    // Only the second stage and its delayed copy are looked at; the first just settles the pin
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = pin_in;
        s_next.sync2 = s_reg.sync1;
        s_next.last = s_reg.sync2;
        s_next.tick = 1'b0;
        rise = s_reg.sync2 & ~s_reg.last;
        if (!run) begin
            s_next.edges = '0; // Fresh second after each enable
        end else if (rise) begin
            if (s_reg.edges == EDGE_LAST) begin
                s_next.edges = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.edges = s_reg.edges + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule // gpt32_rtc_divider

/* gpt32_timer.sv */
`timescale 1ns/100ps
module gpt32_timer #(
    parameter int unsigned rtc_div_edges = gpt32_pkg::RTC_DIV_EDGES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cfg_wr,
    input wire logic [gpt32_pkg::CFG_W-1:0] cfg_wdata,
    input wire logic mode_a_wr,
    input wire logic mode_b_wr,
    input wire logic [gpt32_pkg::MODE_W-1:0] mode_wdata,
    input wire logic ctl_wr,
    input wire logic [gpt32_pkg::CTL_W-1:0] ctl_wdata,
    input wire logic load_wr,
    input wire logic [gpt32_pkg::FULL_W-1:0] load_wdata,
    input wire logic load_b_wr,
    input wire logic [gpt32_pkg::HALF_W-1:0] load_b_wdata,
    input wire logic prescale_a_wr,
    input wire logic prescale_b_wr,
    input wire logic [gpt32_pkg::PRE_W-1:0] prescale_wdata,
    input wire logic match_wr,
    input wire logic [gpt32_pkg::FULL_W-1:0] match_wdata,
    input wire logic [gpt32_pkg::IRQ_W-1:0] irq_mask_reg,
    input wire logic irq_clear_wr,
    input wire logic [gpt32_pkg::IRQ_W-1:0] irq_clear_reg,
    input wire logic debug_halt,
    input wire logic adc_trigger_chain_in,
    input wire logic capture_compare_pin_in,
    output logic [gpt32_pkg::FULL_W-1:0] half_a_count_value,
    output logic [gpt32_pkg::HALF_W-1:0] half_b_count_value,
    output logic [gpt32_pkg::CTL_W-1:0] timer_control_reg,
    output logic [gpt32_pkg::CFG_W-1:0] timer_config_reg,
    output logic [gpt32_pkg::PRE_W-1:0] half_a_prescale,
    output logic [gpt32_pkg::PRE_W-1:0] half_b_prescale,
    output logic [gpt32_pkg::IRQ_W-1:0] raw_irq_status,
    output logic [gpt32_pkg::IRQ_W-1:0] masked_irq_status,
    output logic adc_trigger
);
    typedef struct packed {
        logic [gpt32_pkg::CFG_W-1:0] cfg;
        logic [gpt32_pkg::MODE_W-1:0] mode_a;
        logic [gpt32_pkg::MODE_W-1:0] mode_b;
        logic [gpt32_pkg::CTL_W-1:0] ctl;
        logic [gpt32_pkg::HALF_W-1:0] cnt_a;
        logic [gpt32_pkg::HALF_W-1:0] cnt_b;
        logic [gpt32_pkg::HALF_W-1:0] load_a;
        logic [gpt32_pkg::HALF_W-1:0] load_b;
        logic [gpt32_pkg::PRE_W-1:0] pre_a;
        logic [gpt32_pkg::PRE_W-1:0] pre_b;
        logic [gpt32_pkg::FULL_W-1:0] match;
        logic rtc_seen;
        logic [gpt32_pkg::IRQ_W-1:0] raw;
        logic [gpt32_pkg::IRQ_W-1:0] mis;
        logic adc_own;
        logic adc_out;
        logic [gpt32_pkg::FULL_W-1:0] rd_a;
    } gpt32_state_type;

    localparam gpt32_state_type STATE_RST = '{
        cfg: gpt32_pkg::CFG_TIMER32,
        cnt_a: gpt32_pkg::CNT16_RST,
        cnt_b: gpt32_pkg::CNT16_RST,
        load_a: gpt32_pkg::LOAD16_RST,
        load_b: gpt32_pkg::LOAD16_RST,
        pre_a: gpt32_pkg::PRESCALE_RST,
        pre_b: gpt32_pkg::PRESCALE_RST,
        match: gpt32_pkg::MATCH_RST,
        rd_a: {gpt32_pkg::CNT16_RST, gpt32_pkg::CNT16_RST},
        default: '0
    };

    gpt32_state_type s_reg;
    gpt32_state_type s_next;
    logic [gpt32_pkg::FULL_W-1:0] cnt32;
    logic [gpt32_pkg::FULL_W-1:0] load32;
    logic hold_a;
    logic hold_b;
    logic hold_rtc;
    logic joined_now;
    logic joined_next;
    logic rtc_run;
    logic rtc_tick;
    logic [gpt32_pkg::IRQ_W-1:0] irq_set;
    logic [gpt32_pkg::HALF_W+1:0] step_a;
    logic [gpt32_pkg::HALF_W+1:0] step_b;

    // One 16-bit down-count step: {stop, hit, next count}
    function automatic logic [gpt32_pkg::HALF_W+1:0] half_step(
        input logic [gpt32_pkg::HALF_W-1:0] cnt,
        input logic [gpt32_pkg::HALF_W-1:0] load,
        input logic run,
        input logic [gpt32_pkg::MODE_W-1:0] mode
    );
        logic [gpt32_pkg::HALF_W+1:0] r;
        r = {2'b00, cnt};
        if (run) begin
            if (cnt == gpt32_pkg::HALF_ZERO) begin
                r = {mode == gpt32_pkg::MODE_ONESHOT, 1'b1, load};
            end else begin
                r = {2'b00, cnt - gpt32_pkg::HALF_ONE};
            end
        end
        return r;
    endfunction

    // Joined views of the two halves
    assign cnt32 = {s_reg.cnt_b, s_reg.cnt_a};
    assign load32 = {s_reg.load_b, s_reg.load_a};
    assign joined_now = (s_reg.cfg == gpt32_pkg::CFG_TIMER32) ||
        (s_reg.cfg == gpt32_pkg::CFG_RTC);

    // Freeze conditions; the override wins over either stall bit
    assign hold_a = debug_halt & s_reg.ctl[gpt32_pkg::CTL_STALL_A] &
        ~s_reg.ctl[gpt32_pkg::CTL_RTC_OVR];
    assign hold_b = debug_halt & s_reg.ctl[gpt32_pkg::CTL_STALL_B] &
        ~s_reg.ctl[gpt32_pkg::CTL_RTC_OVR];
    assign hold_rtc = hold_a | hold_b;

    // Divider is held clear unless the clock mode is running
    assign rtc_run = (s_reg.cfg == gpt32_pkg::CFG_RTC) & s_reg.ctl[gpt32_pkg::CTL_EN_A];

    gpt32_rtc_divider #(
        .div_edges(rtc_div_edges)
    ) u_rtc_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(capture_compare_pin_in),
        .run(rtc_run),
        .tick(rtc_tick)
    );

    // Split halves step on their own enables and stalls
    assign step_a = half_step(s_reg.cnt_a, s_reg.load_a,
        s_reg.ctl[gpt32_pkg::CTL_EN_A] & ~hold_a, s_reg.mode_a);
    assign step_b = half_step(s_reg.cnt_b, s_reg.load_b,
        s_reg.ctl[gpt32_pkg::CTL_EN_B] & ~hold_b, s_reg.mode_b);

    // Counting first, then software writes other than status clears override what they touch
    always_comb begin
        s_next = s_reg;
        irq_set = '0;
        s_next.adc_own = 1'b0;
        unique case (s_reg.cfg)
            gpt32_pkg::CFG_TIMER32: begin
                // Half B mode plays no part here
                if (s_reg.ctl[gpt32_pkg::CTL_EN_A] && !hold_a) begin
                    if (cnt32 == gpt32_pkg::FULL_ZERO) begin
                        {s_next.cnt_b, s_next.cnt_a} = load32;
                        irq_set[gpt32_pkg::IRQ_TO_A] = 1'b1;
                        s_next.adc_own = s_reg.ctl[gpt32_pkg::CTL_OTE_A];
                        if (s_reg.mode_a == gpt32_pkg::MODE_ONESHOT) begin
                            s_next.ctl[gpt32_pkg::CTL_EN_A] = 1'b0;
                        end
                    end else begin
                        {s_next.cnt_b, s_next.cnt_a} = cnt32 - gpt32_pkg::FULL_ONE;
                    end
                end
            end
            gpt32_pkg::CFG_RTC: begin
                if (s_reg.ctl[gpt32_pkg::CTL_EN_A] && rtc_tick && !hold_rtc) begin
                    if (cnt32 == s_reg.match) begin
                        {s_next.cnt_b, s_next.cnt_a} = gpt32_pkg::FULL_ZERO;
                        irq_set[gpt32_pkg::IRQ_RTC] = 1'b1;
                    end else begin
                        {s_next.cnt_b, s_next.cnt_a} = cnt32 + gpt32_pkg::FULL_ONE;
                    end
                end
            end
            default: begin
                // Split use: each half is its own 16-bit timer
                s_next.cnt_a = step_a[gpt32_pkg::HALF_W-1:0];
                s_next.cnt_b = step_b[gpt32_pkg::HALF_W-1:0];
                irq_set[gpt32_pkg::IRQ_TO_A] = step_a[gpt32_pkg::HALF_W];
                irq_set[gpt32_pkg::IRQ_TO_B] = step_b[gpt32_pkg::HALF_W];
                s_next.adc_own = step_a[gpt32_pkg::HALF_W] & s_reg.ctl[gpt32_pkg::CTL_OTE_A];
                if (step_a[gpt32_pkg::HALF_W+1]) begin
                    s_next.ctl[gpt32_pkg::CTL_EN_A] = 1'b0;
                end
                if (step_b[gpt32_pkg::HALF_W+1]) begin
                    s_next.ctl[gpt32_pkg::CTL_EN_B] = 1'b0;
                end
            end
        endcase

        // Mode and control writes; a control write beats the one-shot clear
        if (mode_a_wr) begin
            s_next.mode_a = mode_wdata;
        end
        if (mode_b_wr) begin
            s_next.mode_b = mode_wdata;
        end
        if (ctl_wr) begin
            s_next.ctl = ctl_wdata;
        end

        // Interval load written: counter takes the new value at the same edge as the load register
        if (load_wr) begin
            s_next.load_a = load_wdata[gpt32_pkg::HALF_W-1:0];
            if (joined_now) begin
                s_next.load_b = load_wdata[gpt32_pkg::FULL_W-1:gpt32_pkg::HALF_W];
                {s_next.cnt_b, s_next.cnt_a} = load_wdata;
            end else begin
                s_next.cnt_a = load_wdata[gpt32_pkg::HALF_W-1:0];
            end
        end
        if (load_b_wr && !joined_now) begin
            s_next.load_b = load_b_wdata;
            s_next.cnt_b = load_b_wdata;
        end
        if (prescale_a_wr) begin
            s_next.pre_a = prescale_wdata;
        end
        if (prescale_b_wr) begin
            s_next.pre_b = prescale_wdata;
        end
        if (match_wr) begin
            s_next.match = match_wdata;
        end

        // First entry into clock mode starts the count at one
        if (cfg_wr) begin
            s_next.cfg = cfg_wdata;
            if (cfg_wdata == gpt32_pkg::CFG_RTC && !s_reg.rtc_seen) begin
                s_next.rtc_seen = 1'b1;
                {s_next.cnt_b, s_next.cnt_a} = gpt32_pkg::RTC_FIRST_LOAD;
            end
        end

        // Status flags: a new event wins over a clear in the same cycle
        s_next.raw = (s_reg.raw & ~(irq_clear_wr ? irq_clear_reg : '0)) | irq_set;
        s_next.mis = s_next.raw & irq_mask_reg;

        // Trigger leaves as the OR with the other modules' triggers
        s_next.adc_out = s_next.adc_own | adc_trigger_chain_in;

        // Count read view, registered so the output is a plain flop
        joined_next = (s_next.cfg == gpt32_pkg::CFG_TIMER32) ||
            (s_next.cfg == gpt32_pkg::CFG_RTC);
        s_next.rd_a = joined_next ? {s_next.cnt_b, s_next.cnt_a} :
            {gpt32_pkg::HALF_ZERO, s_next.cnt_a};
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign half_a_count_value = s_reg.rd_a;
    assign half_b_count_value = s_reg.cnt_b;
    assign timer_control_reg = s_reg.ctl;
    assign timer_config_reg = s_reg.cfg;
    assign half_a_prescale = s_reg.pre_a;
    assign half_b_prescale = s_reg.pre_b;
    assign raw_irq_status = s_reg.raw;
    assign masked_irq_status = s_reg.mis;
    assign adc_trigger = s_reg.adc_out;

    // Checks
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_zero_hit;
        s_reg.cfg == gpt32_pkg::CFG_TIMER32 && s_reg.ctl[gpt32_pkg::CTL_EN_A] && !hold_a &&
            cnt32 == gpt32_pkg::FULL_ZERO && !load_wr && !cfg_wr;
    endsequence

    sequence s_rtc_match;
        s_reg.cfg == gpt32_pkg::CFG_RTC && s_reg.ctl[gpt32_pkg::CTL_EN_A] && rtc_tick &&
            !hold_rtc && cnt32 == s_reg.match && !load_wr && !cfg_wr;
    endsequence

    chk_timeout_reload: assert property (
        s_zero_hit |=> cnt32 == $past(load32) && s_reg.raw[gpt32_pkg::IRQ_TO_A])
        else $error("count did not reload at zero");
    chk_oneshot_stop: assert property (
        s_zero_hit ##0 (s_reg.mode_a == gpt32_pkg::MODE_ONESHOT && !ctl_wr)
            |=> !s_reg.ctl[gpt32_pkg::CTL_EN_A])
        else $error("one-shot did not clear its enable");
    // A zero load, a stall or a write just after the hit changes the count that follows
    chk_periodic_keep: assert property (
        s_zero_hit ##0 (s_reg.mode_a != gpt32_pkg::MODE_ONESHOT && !ctl_wr &&
            load32 != gpt32_pkg::FULL_ZERO) ##1 (!hold_a && !load_wr && !cfg_wr)
            |-> s_reg.ctl[gpt32_pkg::CTL_EN_A] ##1 cnt32 == $past(load32) - gpt32_pkg::FULL_ONE)
        else $error("periodic timer stopped at zero");
    chk_raw_hold: assert property (
        s_reg.raw[gpt32_pkg::IRQ_TO_A] && !(irq_clear_wr && irq_clear_reg[gpt32_pkg::IRQ_TO_A])
            |=> s_reg.raw[gpt32_pkg::IRQ_TO_A])
        else $error("time-out flag dropped without a clear");
    chk_masked_set: assert property (
        s_zero_hit ##0 irq_mask_reg[gpt32_pkg::IRQ_TO_A] |=> s_reg.mis[gpt32_pkg::IRQ_TO_A])
        else $error("masked time-out flag not set");
    chk_adc_gate: assert property (
        s_reg.adc_own |-> $past(s_reg.ctl[gpt32_pkg::CTL_OTE_A]) && $past(irq_set[gpt32_pkg::IRQ_TO_A]))
        else $error("ADC trigger without enable or time-out");
    chk_adc_or: assert property (
        adc_trigger_chain_in |=> adc_trigger)
        else $error("chained ADC trigger not passed on");
    chk_load_restart: assert property (
        load_wr && joined_now && !cfg_wr |=> cnt32 == $past(load_wdata))
        else $error("counter did not take the new load");
    chk_debug_freeze: assert property (
        s_reg.cfg == gpt32_pkg::CFG_TIMER32 && hold_a && !load_wr && !cfg_wr |=> $stable(cnt32))
        else $error("count moved during debug stall");
    chk_rtc_first: assert property (
        cfg_wr && cfg_wdata == gpt32_pkg::CFG_RTC && !s_reg.rtc_seen
            |=> cnt32 == gpt32_pkg::RTC_FIRST_LOAD && s_reg.rtc_seen)
        else $error("first clock-mode load is not one");
    chk_rtc_rollover: assert property (
        s_rtc_match |=> cnt32 == gpt32_pkg::FULL_ZERO && s_reg.raw[gpt32_pkg::IRQ_RTC])
        else $error("clock count did not roll over at match");

endmodule // gpt32_timer

/* gpt32_timer_test.sv */
`timescale 1ns/100ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: %s", $time, m); end end
module gpt32_timer_test;
    logic core_clk, rst_b, cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_wr, load_b_wr;
    logic prescale_a_wr, prescale_b_wr, match_wr, irq_clear_wr, debug_halt, chain_in, pin;
    logic [2:0] cfg_wdata, irq_mask, irq_clr;
    logic [1:0] mode_wdata;
    logic [5:0] ctl_wdata;
    logic [31:0] load_wdata, match_wdata, cnt, hold;
    logic [15:0] load_b_wdata, cnt_b;
    logic [7:0] prescale_wdata, pre_a, pre_b;
    logic [5:0] ctl;
    logic [2:0] cfg, raw, msk;
    logic adc;
    int err_total = 0;
    int check_count = 0;
    int adc_seen = 0;

    gpt32_timer #(.rtc_div_edges(4)) i_gpt32_timer (.core_clk(core_clk), .rst_b(rst_b),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .mode_a_wr(mode_a_wr), .mode_b_wr(mode_b_wr),
        .mode_wdata(mode_wdata), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .load_wr(load_wr),
        .load_wdata(load_wdata), .load_b_wr(load_b_wr), .load_b_wdata(load_b_wdata),
        .prescale_a_wr(prescale_a_wr), .prescale_b_wr(prescale_b_wr),
        .prescale_wdata(prescale_wdata), .match_wr(match_wr), .match_wdata(match_wdata),
        .irq_mask_reg(irq_mask), .irq_clear_wr(irq_clear_wr), .irq_clear_reg(irq_clr),
        .debug_halt(debug_halt), .adc_trigger_chain_in(chain_in),
        .capture_compare_pin_in(pin), .half_a_count_value(cnt), .half_b_count_value(cnt_b),
        .timer_control_reg(ctl), .timer_config_reg(cfg), .half_a_prescale(pre_a),
        .half_b_prescale(pre_b), .raw_irq_status(raw), .masked_irq_status(msk),
        .adc_trigger(adc));

    // Core clock, 25 ns
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Slow pin clock, free running, eight core cycles per level
    initial begin
        pin = 1'b0;
        forever begin
            repeat (8) @(negedge core_clk);
            pin = ~pin;
        end
    end
    // Trigger pulses are one cycle wide, so count them on every rising edge
    always @(posedge core_clk) begin
        if (adc === 1'b1) adc_seen++;
    end

    // One strobe per write; strobes drop at the following falling edge
    task automatic wr(input int sel, input logic [31:0] d);
        @(negedge core_clk);
        case (sel)
            0: begin cfg_wr = 1'b1; cfg_wdata = d[2:0]; end
            1: begin mode_a_wr = 1'b1; mode_wdata = d[1:0]; end
            2: begin mode_b_wr = 1'b1; mode_wdata = d[1:0]; end
            3: begin ctl_wr = 1'b1; ctl_wdata = d[5:0]; end
            4: begin load_wr = 1'b1; load_wdata = d; end
            5: begin load_b_wr = 1'b1; load_b_wdata = d[15:0]; end
            6: begin prescale_a_wr = 1'b1; prescale_wdata = d[7:0]; end
            7: begin prescale_b_wr = 1'b1; prescale_wdata = d[7:0]; end
            8: begin match_wr = 1'b1; match_wdata = d; end
            default: begin irq_clear_wr = 1'b1; irq_clr = d[2:0]; end
        endcase
        @(negedge core_clk);
        {cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_wr, load_b_wr} = '0;
        {prescale_a_wr, prescale_b_wr, match_wr, irq_clear_wr} = '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Bounded wait for a count value, then compare it
    task automatic wait_cnt(input logic [31:0] exp);
        int n;
        n = 0;
        while (cnt !== exp && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(cnt, exp, "count never reached expected value")
    endtask

    task automatic wait_raw(input int b);
        int n;
        n = 0;
        while (raw[b] !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this limit of 8000 cycles is far beyond it
    initial begin
        #200000;
        err_total++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end

    initial begin
        {cfg_wr, mode_a_wr, mode_b_wr, ctl_wr, load_wr, load_b_wr} = '0;
        {prescale_a_wr, prescale_b_wr, match_wr, irq_clear_wr, debug_halt, chain_in} = '0;
        cfg_wdata = 3'h0; mode_wdata = 2'h0; ctl_wdata = 6'h00; load_wdata = 32'h0;
        load_b_wdata = 16'h0; prescale_wdata = 8'h00; match_wdata = 32'h0; irq_clr = 3'h0;
        irq_mask = 3'h5;
        rst_b = 1'b0;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK(cnt, 32'hffff_ffff, "count after reset")
        `CHK({ctl, cfg, raw, msk}, 15'h0000, "controls after reset")
        `CHK({pre_a, pre_b}, 16'h0000, "prescales after reset")
        $display("test reset done");
        // Prescale storage and joined load word order
        wr(6, 32'h5a); wr(7, 32'ha5);
        `CHK({pre_a, pre_b}, 16'h5aa5, "prescale write")
        wr(4, 32'h0001_0002);
        `CHK(cnt, 32'h0001_0002, "joined count read")
        `CHK(cnt_b, 16'h0001, "upper half load")
        $display("test joined load done");
        // One-shot: half B mode says periodic and must be ignored
        wr(2, 32'h2); wr(1, 32'h1); wr(4, 32'h3); wr(3, 32'h05);
        wait_raw(0);
        `CHK(cnt, 32'h3, "one-shot reload")
        `CHK(ctl[0], 1'b0, "one-shot enable clear")
        idle(3);
        `CHK(cnt, 32'h3, "one-shot stopped")
        `CHK(raw[0], 1'b1, "time-out flag held")
        `CHK(msk[0], 1'b1, "masked time-out")
        `CHK(adc_seen, 1, "trigger pulse count")
        wr(9, 32'h1); idle(1);
        `CHK({raw[0], msk[0]}, 2'b00, "time-out clear")
        $display("test one-shot done");
        // Periodic without trigger, reload written mid-run
        wr(1, 32'h2); wr(4, 32'h20); wr(3, 32'h01); idle(2);
        wr(4, 32'h5);
        `CHK(cnt, 32'h5, "reload while running")
        wait_raw(0); idle(2);
        `CHK(ctl[0], 1'b1, "periodic keeps enable")
        `CHK(adc_seen, 1, "no trigger without enable")
        $display("test periodic done");
        // Debug halt with stall, then stall override
        debug_halt = 1'b1;
        wr(3, 32'h09); hold = cnt; idle(4);
        `CHK(cnt, hold, "stall freezes count")
        wr(3, 32'h29); hold = cnt; idle(2);
        `CHK(cnt !== hold, 1'b1, "override keeps counting")
        wr(3, 32'h00); debug_halt = 1'b0; wr(9, 32'h7);
        $display("test stall done");
        // Trigger from another module passes through
        hold = adc_seen;
        @(negedge core_clk); chain_in = 1'b1;
        @(negedge core_clk); chain_in = 1'b0;
        idle(2);
        `CHK(adc_seen, hold + 1, "chained trigger")
        $display("test chain done");
        // Clock mode: first entry loads one, counts up at divided rate
        wr(0, 32'h1);
        `CHK(cnt, 32'h1, "first clock-mode load")
        `CHK(cfg, 3'h1, "clock mode config")
        wr(8, 32'h3); wr(3, 32'h01);
        wait_cnt(32'h2);
        wait_cnt(32'h3);
        wait_cnt(32'h0);
        `CHK(raw[2], 1'b1, "clock match flag")
        idle(1);
        `CHK(msk[2], 1'b1, "clock masked flag")
        wait_cnt(32'h1);
        wr(9, 32'h4); idle(1);
        `CHK({raw[2], msk[2]}, 2'b00, "clock flag clear")
        wr(3, 32'h00);
        $display("test clock mode done");
        // Split halves load separately
        wr(0, 32'h4); wr(5, 32'h7); wr(4, 32'h1234_0009);
        `CHK(cnt, 32'h0000_0009, "split lower half")
        `CHK(cnt_b, 16'h0007, "split upper half")
        // Half A one-shot from 9, half B periodic from 7, both enabled together
        wr(1, 32'h1); wr(3, 32'h03); idle(12);
        `CHK(cnt, 32'h0000_0009, "split half A one-shot reload")
        `CHK(cnt_b, 16'h0003, "split half B periodic count")
        `CHK(ctl[1:0], 2'h2, "split enables")
        `CHK({raw[1:0], msk[1:0]}, 4'hd, "split time-out flags")
        $display("test split done");
        end_sim();
    end
endmodule // gpt32_timer_test
